// file: src/pwmtf_pkg.sv
// package: register map, field positions and timing constants for the trigger/prescaler block
package pwmtf_pkg;
    // ------------------------------------------------------------
    // register indices (printed offsets are not word aligned)
    // ------------------------------------------------------------
    localparam logic [15:0] ROUTE_IDX    = 16'hf4da;
    localparam logic [15:0] SAMPLE_IDX   = 16'hf4db;
    localparam logic [15:0] DIVIDER_IDX  = 16'hf4dc;
    localparam logic [15:0] MODE_IDX     = 16'hf4dd;
    localparam logic [15:0] STATUS_IDX   = 16'hf4de;
    localparam int          ADDR_W       = 18;
    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ROUTE_MASK   = 8'h05;
    localparam logic [7:0]  SAMPLE_MASK  = 8'h33;
    localparam logic [7:0]  DIVIDER_MASK = 8'h07;
    localparam logic [7:0]  MODE_MASK    = 8'h07;
    localparam logic [7:0]  REG_RESET    = 8'h00;
    localparam int          ROUTE_EV0    = 0;
    localparam int          ROUTE_EV1    = 2;
    localparam int          SAMPLE_EV0   = 0;
    localparam int          SAMPLE_EV1   = 4;
    localparam int          MODE_COUPLED = 0;
    localparam int          MODE_DEAD    = 1;
    localparam int          MODE_ONESHOT = 2;
    localparam logic [2:0]  DIV_RESERVED = 3'h7;
    localparam logic [1:0]  SRC_OSC      = 2'h1;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // ------------------------------------------------------------
    // timing: filter lengths in sample clocks, filter and divider counter widths
    // ------------------------------------------------------------
    localparam int          LS_SAMPLES   = 2;
    localparam int          OSC_BASE     = 2;
    localparam int          FILT_CNT_W   = 5;
    localparam int          DIV_CNT_W    = 6;
endpackage

// file: src/pwmtf_top.sv
// module: event routing, sampling filter and clock divider for one pwm channel pair member
// Notes on behaviour
// - route bit two picks second event pin
// - route bit zero picks first event pin
// - coupled mode uses partner route bits
// - second input filter 2/4/8/16 oscillator clocks
// - first input filter same encoding
// - non-oscillator source fixes two low-speed clocks
// - coupled mode uses partner sampling fields
// - divider codes give 1 to 64
// - code 111 acts as undivided
// - coupled mode uses partner divider field
// - single repeat: channel runs continuously alone
// - single one-shot: one period then stops
// - coupled repeat: channels count together
// - coupled one-shot: single shared period
// - dead-time select enables dead-time insertion in coupled mode only
// - four start modes, two routable inputs
// - sample on oscillator else low-speed clock
//
// The implementer's own choice: the AXI4-Lite register port.
module pwmtf_top (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [17:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [17:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        first_event_pin_a,
    input  wire logic        first_event_pin_b,
    input  wire logic        second_event_pin_a,
    input  wire logic        second_event_pin_b,
    input  wire logic [7:0]  partner_route,
    input  wire logic [7:0]  partner_sampling,
    input  wire logic [2:0]  partner_divider,
    input  wire logic [1:0]  clock_source,
    input  wire logic        low_speed_tick,
    input  wire logic        oscillator_tick,
    input  wire logic        external_tick,
    input  wire logic        period_end,
    input  wire logic        run_request,
    output logic             first_event_filtered,
    output logic             second_event_filtered,
    output logic             channel_tick,
    output logic             channel_running,
    output logic             pair_joint_count,
    output logic             deadtime_active_en
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [7:0]  route, next_route;
    logic [7:0]  sampling, next_sampling;
    logic [7:0]  divider, next_divider;
    logic [7:0]  mode, next_mode;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [1:0]  rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic        wr_go, rd_go;
    logic [15:0] wr_idx, rd_idx;
    logic [7:0]  wbyte;
    logic [7:0]  status;

    // both channels taken together keeps the slave stateless between beats
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid;
    assign rd_go         = s_axi_arvalid && !rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;
    assign wr_idx        = s_axi_awaddr[17:2];
    assign rd_idx        = s_axi_araddr[17:2];
    assign wbyte         = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;

    always_comb begin
        next_route    = route;
        next_sampling = sampling;
        next_divider  = divider;
        next_mode     = mode;
        next_bvalid   = bvalid && !s_axi_bready;
        next_bresp    = bresp;
        next_rvalid   = rvalid && !s_axi_rready;
        next_rresp    = rresp;
        next_rdata    = rdata;
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp  = pwmtf_pkg::RESP_OKAY;
            if (s_axi_wstrb[0]) begin
                unique case (wr_idx)
                    pwmtf_pkg::ROUTE_IDX:   next_route    = wbyte & pwmtf_pkg::ROUTE_MASK;
                    pwmtf_pkg::SAMPLE_IDX:  next_sampling = wbyte & pwmtf_pkg::SAMPLE_MASK;
                    pwmtf_pkg::DIVIDER_IDX: next_divider  = wbyte & pwmtf_pkg::DIVIDER_MASK;
                    pwmtf_pkg::MODE_IDX:    next_mode     = wbyte & pwmtf_pkg::MODE_MASK;
                    pwmtf_pkg::STATUS_IDX:  next_bresp    = pwmtf_pkg::RESP_OKAY;
                    default:                next_bresp    = pwmtf_pkg::RESP_SLVERR;
                endcase
            end
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp  = pwmtf_pkg::RESP_OKAY;
            unique case (rd_idx)
                pwmtf_pkg::ROUTE_IDX:   next_rdata = {24'h00_0000, route};
                pwmtf_pkg::SAMPLE_IDX:  next_rdata = {24'h00_0000, sampling};
                pwmtf_pkg::DIVIDER_IDX: next_rdata = {24'h00_0000, divider};
                pwmtf_pkg::MODE_IDX:    next_rdata = {24'h00_0000, mode};
                pwmtf_pkg::STATUS_IDX:  next_rdata = {24'h00_0000, status};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = pwmtf_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            route    <= pwmtf_pkg::REG_RESET;
            sampling <= pwmtf_pkg::REG_RESET;
            divider  <= pwmtf_pkg::REG_RESET;
            mode     <= pwmtf_pkg::REG_RESET;
            bvalid   <= 1'b0;
            bresp    <= 2'h0;
            rvalid   <= 1'b0;
            rresp    <= 2'h0;
            rdata    <= 32'h0000_0000;
        end else begin
            route    <= next_route;
            sampling <= next_sampling;
            divider  <= next_divider;
            mode     <= next_mode;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rresp    <= next_rresp;
            rdata    <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // effective settings and pin routing
    // ------------------------------------------------------------
    logic       coupled;
    logic [7:0] eff_route, eff_sampling;
    logic [2:0] eff_div;
    logic       osc_src;
    logic       sample_tick, src_tick;
    logic [1:0] ev_raw;
    logic [1:0] ev_code [2];

    assign coupled      = mode[pwmtf_pkg::MODE_COUPLED];
    assign eff_route    = coupled ? partner_route : route;
    assign eff_sampling = coupled ? partner_sampling : sampling;
    assign eff_div      = coupled ? partner_divider : divider[2:0];
    assign ev_raw[0]    = eff_route[pwmtf_pkg::ROUTE_EV0] ? first_event_pin_b
                                                          : first_event_pin_a;
    assign ev_raw[1]    = eff_route[pwmtf_pkg::ROUTE_EV1] ? second_event_pin_b
                                                          : second_event_pin_a;
    assign ev_code[0]   = eff_sampling[pwmtf_pkg::SAMPLE_EV0 +: 2];
    assign ev_code[1]   = eff_sampling[pwmtf_pkg::SAMPLE_EV1 +: 2];
    assign osc_src      = (clock_source == pwmtf_pkg::SRC_OSC);
    assign sample_tick  = osc_src ? oscillator_tick : low_speed_tick;
    assign src_tick     = osc_src ? oscillator_tick
                        : (clock_source[1] ? external_tick : low_speed_tick);

    // ------------------------------------------------------------
    // sampling filters, one per event input
    // ------------------------------------------------------------
    logic [1:0] filt_out;
    generate
        for (genvar i = 0; i < 2; i++) begin : g_filt
            logic [pwmtf_pkg::FILT_CNT_W-1:0] cnt, next_cnt, need;
            logic                             stable, next_stable;
            always_comb begin
                // with the oscillator source code n requires 2^(n+1) agreeing samples, otherwise two
                need = osc_src ? pwmtf_pkg::FILT_CNT_W'(pwmtf_pkg::OSC_BASE << ev_code[i])
                               : pwmtf_pkg::FILT_CNT_W'(pwmtf_pkg::LS_SAMPLES);
                next_cnt    = cnt;
                next_stable = stable;
                if (sample_tick) begin
                    if (ev_raw[i] == stable) begin
                        next_cnt = '0;
                    end else if (cnt + 1'b1 >= need) begin
                        next_stable = ev_raw[i];
                        next_cnt    = '0;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            end
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    cnt    <= '0;
                    stable <= 1'b0;
                end else begin
                    cnt    <= next_cnt;
                    stable <= next_stable;
                end
            end
            assign filt_out[i] = stable;
        end
    endgenerate
    assign first_event_filtered  = filt_out[0];
    assign second_event_filtered = filt_out[1];

    // ------------------------------------------------------------
    // prescaler and run control
    // ------------------------------------------------------------
    logic [pwmtf_pkg::DIV_CNT_W-1:0] pre, next_pre, div_mask;
    logic                            tick, next_tick;
    logic                            running, next_running;

    always_comb begin
        // 111 falls back to no division
        div_mask = (eff_div == pwmtf_pkg::DIV_RESERVED) ? '0
                 : pwmtf_pkg::DIV_CNT_W'((7'h01 << eff_div) - 7'h01);
        next_pre  = pre;
        next_tick = 1'b0;
        if (src_tick) begin
            if ((pre & div_mask) == div_mask) begin
                next_pre  = '0;
                next_tick = 1'b1;
            end else begin
                next_pre = pre + 1'b1;
            end
        end
        next_running = running;
        if (run_request) begin
            next_running = 1'b1;
        end else if (period_end && mode[pwmtf_pkg::MODE_ONESHOT]) begin
            next_running = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pre     <= '0;
            tick    <= 1'b0;
            running <= 1'b0;
        end else begin
            pre     <= next_pre;
            tick    <= next_tick;
            running <= next_running;
        end
    end

    assign channel_tick       = tick;
    assign channel_running    = running;
    assign pair_joint_count   = coupled;
    assign deadtime_active_en = coupled && mode[pwmtf_pkg::MODE_DEAD];
    assign status             = {5'h00, running, filt_out[1], filt_out[0]};
endmodule

// file: tb/pwmtf_monitor.sv
// checker: bus answers, filter sampling, divider ticks and run start
module pwmtf_monitor (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic [1:0] clock_source,
    input wire logic       low_speed_tick,
    input wire logic       oscillator_tick,
    input wire logic       external_tick,
    input wire logic       run_request,
    input wire logic       first_event_filtered,
    input wire logic       second_event_filtered,
    input wire logic       channel_tick,
    input wire logic       channel_running
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // sample and source ticks
    // ----
    logic samp_tick;
    logic src_tick;
    // only the oscillator source gets its own sampling clock
    assign samp_tick = (clock_source == pwmtf_pkg::SRC_OSC) ? oscillator_tick : low_speed_tick;
    assign src_tick  = clock_source[1] ? external_tick : samp_tick;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_wr_answer:
    assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write not answered");
    chk_wr_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_rd_answer:
    assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered");
    chk_rd_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    chk_tick_source:
    assert property (channel_tick |-> $past(src_tick))
        else $error("divided tick without source tick");
    chk_filt_first:
    assert property ($changed(first_event_filtered) |-> $past(samp_tick))
        else $error("first filter moved off its sample tick");
    chk_filt_second:
    assert property ($changed(second_event_filtered) |-> $past(samp_tick))
        else $error("second filter moved off its sample tick");
    chk_run_start:
    assert property (run_request |=> channel_running)
        else $error("run request did not start the channel");
endmodule
bind pwmtf_top pwmtf_monitor u_mon (
    .sys_clk, .reset_n, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .clock_source, .low_speed_tick,
    .oscillator_tick, .external_tick, .run_request, .first_event_filtered,
    .second_event_filtered, .channel_tick, .channel_running
);

// file: tb/pwmtf_event_pins.sv
// partner: external event pins, the picked pin carries the event level
module pwmtf_event_pins (
    input  wire logic lvl0,
    input  wire logic lvl1,
    input  wire logic pick0,
    input  wire logic pick1,
    output logic      first_event_pin_a,
    output logic      first_event_pin_b,
    output logic      second_event_pin_a,
    output logic      second_event_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // pins
    // ----
    // the idle pin shows the inverse, so a wrong route cannot pass
    assign first_event_pin_a  = pick0 ? !lvl0 : lvl0;
    assign first_event_pin_b  = pick0 ? lvl0 : !lvl0;
    assign second_event_pin_a = pick1 ? !lvl1 : lvl1;
    assign second_event_pin_b = pick1 ? lvl1 : !lvl1;
endmodule

// file: tb/pwm_trigger_filter_prescaler_tb_top.sv
// testbench: register map, routing, filter, divider and mode checks
module pwm_trigger_filter_prescaler_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, reset_n = 1'b0, period_end = 1'b0, run_request = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lvl0 = 1'b0, lvl1 = 1'b0;
    logic        pick0 = 1'b0, pick1 = 1'b0;
    logic        low_speed_tick = 1'b1, oscillator_tick = 1'b1, external_tick = 1'b1;
    logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, got;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic [7:0]  partner_route = 8'h05, partner_sampling = 8'h33;
    logic [2:0]  partner_divider = 3'h6;
    logic [1:0]  clock_source = 2'h1, s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        first_event_pin_a, first_event_pin_b, second_event_pin_a, second_event_pin_b;
    logic        first_event_filtered, second_event_filtered, channel_tick, channel_running;
    logic        pair_joint_count, deadtime_active_en;
    logic [15:0] idx [4] = '{pwmtf_pkg::ROUTE_IDX, pwmtf_pkg::SAMPLE_IDX,
                             pwmtf_pkg::DIVIDER_IDX, pwmtf_pkg::MODE_IDX};
    logic [7:0]  msk [4] = '{pwmtf_pkg::ROUTE_MASK, pwmtf_pkg::SAMPLE_MASK,
                             pwmtf_pkg::DIVIDER_MASK, pwmtf_pkg::MODE_MASK};
    int          bad_count = 0, checked = 0, t0, t1, b0, b1;
    always #5 sys_clk = ~sys_clk;
    pwmtf_event_pins u_pins (.lvl0, .lvl1, .pick0, .pick1, .first_event_pin_a,
        .first_event_pin_b, .second_event_pin_a, .second_event_pin_b);
    pwmtf_top u_dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .first_event_pin_a, .first_event_pin_b,
        .second_event_pin_a, .second_event_pin_b, .partner_route, .partner_sampling,
        .partner_divider, .clock_source, .low_speed_tick, .oscillator_tick, .external_tick,
        .period_end, .run_request, .first_event_filtered, .second_event_filtered,
        .channel_tick, .channel_running, .pair_joint_count, .deadtime_active_en);
    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: %s got %0h want %0h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        s_axi_awaddr  <= {a, 2'b00};
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge sys_clk);
        s_axi_araddr  <= {a, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        got  = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // flips both event levels and returns cycles until each output follows
    task automatic meas(output int a, output int b);
        @(posedge sys_clk);
        lvl0 <= !lvl0;
        lvl1 <= !lvl1;
        a = 0;
        b = 0;
        for (int n = 1; n < 60; n++) begin
            @(posedge sys_clk);
            if (a == 0 && first_event_filtered === lvl0) a = n;
            if (b == 0 && second_event_filtered === lvl1) b = n;
        end
    endtask
    task automatic ticks(output int k);
        k = 0;
        repeat (70) @(posedge sys_clk);
        repeat (256) begin
            @(posedge sys_clk);
            if (channel_tick === 1'b1) k++;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(idx[i]);
            chk(got, 32'h0000_0000, "reset value");
            wr(idx[i], 8'hff);
            rd(idx[i]);
            chk(got, {24'h00_0000, msk[i]}, "reserved bits");
            wr(idx[i], 8'h00);
        end
        rd(16'hf4df);
        chk(32'(resp), 32'(pwmtf_pkg::RESP_SLVERR), "unmapped read");
        $display("test registers finished");
        // own route bits, then the partner's once coupled
        for (int i = 0; i < 3; i++) begin
            wr(pwmtf_pkg::MODE_IDX, {7'h00, i == 2});
            wr(pwmtf_pkg::ROUTE_IDX, (i == 1) ? 8'h05 : 8'h00);
            pick0 <= (i > 0);
            pick1 <= (i > 0);
            repeat (2) begin
                meas(t0, t1);
                chk(32'(first_event_filtered), 32'(lvl0), "first route");
                chk(32'(second_event_filtered), 32'(lvl1), "second route");
            end
        end
        $display("test routing finished");
        pick0 <= 1'b0;
        pick1 <= 1'b0;
        wr(pwmtf_pkg::MODE_IDX, 8'h00);
        wr(pwmtf_pkg::ROUTE_IDX, 8'h00);
        meas(b0, b1);
        meas(b0, b1);
        for (int c = 0; c < 4; c++) begin
            wr(pwmtf_pkg::SAMPLE_IDX, {2'b00, 2'(3 - c), 2'b00, 2'(c)});
            meas(t0, t1);
            chk(32'(t0 - b0), 32'((2 << c) - 2), "first filter");
            chk(32'(t1 - b1), 32'((2 << (3 - c)) - 2), "second filter");
        end
        // oscillator ticks stop, so only low-speed sampling can move the filters
        clock_source    <= 2'h0;
        oscillator_tick <= 1'b0;
        wr(pwmtf_pkg::SAMPLE_IDX, 8'h33);
        meas(t0, t1);
        chk(32'(t0 - b0 + t1 - b1), 32'h0000_0000, "low speed filter");
        // low-speed ticks stop, so only oscillator sampling can move the filters
        clock_source    <= 2'h1;
        oscillator_tick <= 1'b1;
        low_speed_tick  <= 1'b0;
        pick0 <= 1'b1;
        pick1 <= 1'b1;
        wr(pwmtf_pkg::MODE_IDX, 8'h01);
        wr(pwmtf_pkg::SAMPLE_IDX, 8'h00);
        meas(t0, t1);
        meas(t0, t1);
        chk(32'(t0 - b0 + t1 - b1), 32'(28), "coupled filter");
        $display("test filter finished");
        // only the external source ticks; code 11 selects it, as code 10 also would
        clock_source    <= 2'h3;
        oscillator_tick <= 1'b0;
        for (int c = 0; c < 9; c++) begin
            wr(pwmtf_pkg::MODE_IDX, {7'h00, c == 8});
            wr(pwmtf_pkg::DIVIDER_IDX, 8'(c & 7));
            ticks(t0);
            chk(32'(t0), (c == 7) ? 32'(256) : (c == 8) ? 32'(4) : 32'(256 >> c),
                "divider");
        end
        low_speed_tick  <= 1'b1;
        oscillator_tick <= 1'b1;
        $display("test divider finished");
        for (int m = 0; m < 8; m++) begin
            wr(pwmtf_pkg::MODE_IDX, 8'(m));
            chk(32'(pair_joint_count), 32'(m & 1), "joint count");
            chk(32'(deadtime_active_en), 32'(m == 3 || m == 7), "dead time");
            run_request <= 1'b1;
            @(posedge sys_clk);
            run_request <= 1'b0;
            period_end  <= 1'b1;
            @(posedge sys_clk);
            period_end  <= 1'b0;
            repeat (2) @(posedge sys_clk);
            chk(32'(channel_running), 32'(m < 4), "run after period");
        end
        rd(pwmtf_pkg::STATUS_IDX);
        chk(got, {24'h00_0000, 5'h00, 1'b0, lvl1, lvl0}, "status");
        $display("test modes finished");
        summarize();
    end
endmodule
